// [rtcc_defs.vh]
// Register offsets, field positions and constants for the calendar/alarm block
`ifndef RTCC_DEFS_VH
`define RTCC_DEFS_VH
`define RTCC_A_SEC 8'h00
`define RTCC_A_MIN 8'h01
`define RTCC_A_HOUR 8'h02
`define RTCC_A_DAY 8'h03
`define RTCC_A_MON 8'h04
`define RTCC_A_YEAR 8'h05
`define RTCC_A_WEEK 8'h06
`define RTCC_A_ASEC 8'h08
`define RTCC_A_AMIN 8'h09
`define RTCC_A_AHOUR 8'h0a
`define RTCC_A_ADAY 8'h0b
`define RTCC_A_AMON 8'h0c
`define RTCC_A_AYEAR 8'h0d
`define RTCC_A_CTRL 8'h10
`define RTCC_A_STAT 8'h11
`define RTCC_A_INTR 8'h12
`define RTCC_A_CMPL 8'h13
`define RTCC_A_CMPM 8'h14
`define RTCC_MASK_SEC 8'h7f
`define RTCC_MASK_HOUR 8'hbf
`define RTCC_MASK_DAY 8'h3f
`define RTCC_MASK_MON 8'h1f
`define RTCC_MASK_WEEK 8'h07
`define RTCC_MASK_INTR 8'h1f
`define RTCC_RST_ONE 8'h01
`define RTCC_RST_STAT 8'h80
`define RTCC_C_RSEL 7
`define RTCC_C_SNAP 6
`define RTCC_C_LOAD 5
`define RTCC_C_TEST 4
`define RTCC_C_H12 3
`define RTCC_C_AUTO 2
`define RTCC_C_ROUND 1
`define RTCC_C_RUN 0
`define RTCC_S_PWR 7
`define RTCC_S_ALARM 6
`define RTCC_S_RUN 1
`define RTCC_I_ALARM 3
`define RTCC_SUB_LAST 15'h7fff
`define RTCC_WEEK_LAST 3'h6
`define RTCC_HOUR_SECS 12'he0f
`endif

// [rtcc_sync.v]
// Two-flop synchroniser with rising-edge detect on the synchronised level
`timescale 1ns/100ps
module rtcc_sync (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire async_i,
    output wire level_o,
    output wire rise_o
);
    reg meta;
    reg sync;
    reg prev;
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= async_i;
            sync <= meta;
            prev <= sync;
        end
    end
    assign level_o = sync;
    assign rise_o = sync & ~prev;
endmodule // rtcc_sync

// [rtcc_bcd.v]
// One BCD digit pair incrementer with wrap value and carry out
`timescale 1ns/100ps
module rtcc_bcd (
    input wire [7:0] val_i,
    input wire [7:0] first_i,
    input wire [7:0] last_i,
    output reg [7:0] next_o,
    output wire wrap_o
);
    assign wrap_o = (val_i == last_i);
    always @* begin
        if (val_i == last_i) begin
            next_o = first_i;
        end else if (val_i[3:0] == 4'h9) begin
            next_o = {val_i[7:4] + 4'h1, 4'h0};
        end else begin
            next_o = val_i + 8'h01;
        end
    end
endmodule // rtcc_bcd

// [rtcc_core.v]
// Calendar, alarm and clock control register block on a 32 kHz tick
`timescale 1ns/100ps
`include "rtcc_defs.vh"
module rtcc_core (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire clk32k_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    output wire alarm_irq_n_o
);
    // Time index 0..6 = sec,min,hour,day,month,year,week
    reg [7:0] live [0:6];
    reg [7:0] shadow [0:6];
    reg [7:0] alarm [0:5];
    reg [7:0] ctrl;
    reg [7:0] intr;
    reg [15:0] comp;
    reg [14:0] sub;
    reg [11:0] hour_secs;
    reg alarm_flag;
    reg pwr_flag;
    reg run_state;
    reg snap_armed;
    // Step strobe one cycle late, so the alarm compare sees the new time
    reg sec_done;
    wire tick;
    wire [7:0] stat;
    wire sec_update;
    rtcc_sync u_tick (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .async_i(clk32k_i),
        .level_o(),
        .rise_o(tick)
    );

    // Masks of readable bits per time slot
    function [7:0] tmask;
        input [2:0] idx;
        begin
            case (idx)
                3'd0: tmask = `RTCC_MASK_SEC;
                3'd1: tmask = `RTCC_MASK_SEC;
                3'd2: tmask = `RTCC_MASK_HOUR;
                3'd3: tmask = `RTCC_MASK_DAY;
                3'd4: tmask = `RTCC_MASK_MON;
                3'd5: tmask = 8'hff;
                default: tmask = `RTCC_MASK_WEEK;
            endcase
        end
    endfunction

    // Last day of a month, leap year when year divisible by four
    reg [7:0] mlast;
    wire leap = ((live[5][4] == 1'b0) && (live[5][1:0] == 2'b00) && (live[5][3:0] != 4'h2)
        && (live[5][3:0] != 4'h6)) || ((live[5][4] == 1'b1) && ((live[5][3:0] == 4'h2)
        || (live[5][3:0] == 4'h6)));
    always @* begin
        case (live[4])
            8'h02: mlast = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: mlast = 8'h30;
            default: mlast = 8'h31;
        endcase
    end

    wire h12 = ctrl[`RTCC_C_H12];
    wire [7:0] hour_v = {1'b0, 1'b0, live[2][5:0]};
    wire [7:0] hour_first = h12 ? 8'h01 : 8'h00;
    wire [7:0] hour_last = h12 ? 8'h12 : 8'h23;
    wire [7:0] n_sec, n_min, n_hour, n_day, n_mon, n_year;
    wire w_sec, w_min, w_hour, w_day, w_mon;
    rtcc_bcd u_sec (.val_i(live[0]), .first_i(8'h00), .last_i(8'h59),
        .next_o(n_sec), .wrap_o(w_sec));
    rtcc_bcd u_min (.val_i(live[1]), .first_i(8'h00), .last_i(8'h59),
        .next_o(n_min), .wrap_o(w_min));
    rtcc_bcd u_hour (.val_i(hour_v), .first_i(hour_first), .last_i(hour_last),
        .next_o(n_hour), .wrap_o(w_hour));
    rtcc_bcd u_day (.val_i(live[3]), .first_i(8'h01), .last_i(mlast),
        .next_o(n_day), .wrap_o(w_day));
    rtcc_bcd u_mon (.val_i(live[4]), .first_i(8'h01), .last_i(8'h12),
        .next_o(n_mon), .wrap_o(w_mon));
    rtcc_bcd u_year (.val_i(live[5]), .first_i(8'h00), .last_i(8'h99),
        .next_o(n_year), .wrap_o());

    // 12h: 11 -> 12 flips PM; 12 wraps to 01 within the same half
    wire pm = live[2][7];
    wire pm_flip = h12 && (hour_v == 8'h11);
    wire day_carry = h12 ? (pm && (hour_v == 8'h11)) : w_hour;
    wire run_live = run_state;
    assign sec_update = run_live && tick && (sub == `RTCC_SUB_LAST);

    // Per-slot alarm compare; the PM flag rides in bit 7 of the hour slot
    wire [5:0] field_eq;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_match
            assign field_eq[g] = (alarm[g] == live[g]);
        end
    endgenerate

    // Write side of control
    wire wr_ctrl = wr_i && (addr_i == `RTCC_A_CTRL);
    wire round_go = ctrl[`RTCC_C_ROUND];
    wire round_up = round_go && (live[0][6:4] >= 3'h3);
    wire comp_now = run_live && tick && (sub == `RTCC_SUB_LAST) && ctrl[`RTCC_C_AUTO] &&
        (ctrl[`RTCC_C_TEST] || (hour_secs == `RTCC_HOUR_SECS));

    // 24h <-> 12h conversion of the live hour on a mode change
    reg [7:0] conv_hour;
    always @* begin
        conv_hour = live[2];
        if (wdata_i[`RTCC_C_H12] && !h12) begin
            if (live[2] == 8'h00) conv_hour = 8'h12;
            else if (live[2] == 8'h12) conv_hour = 8'h92;
            else if (live[2] > 8'h12) begin
                // 13..19 lose twelve in the units digit; 20..23 need a table
                case (live[2])
                    8'h20: conv_hour = 8'h88;
                    8'h21: conv_hour = 8'h89;
                    8'h22: conv_hour = 8'h90;
                    8'h23: conv_hour = 8'h91;
                    default: conv_hour = {1'b1, 1'b0, 2'b00, live[2][3:0] - 4'h2};
                endcase
            end
        end else if (!wdata_i[`RTCC_C_H12] && h12) begin
            if (live[2] == 8'h12) conv_hour = 8'h00;
            else if (live[2] == 8'h92) conv_hour = 8'h12;
            else if (pm) begin
                // 8 and 9 PM carry into the tens digit, so plain BCD add fails
                case (live[2][5:0])
                    6'h08: conv_hour = 8'h20;
                    6'h09: conv_hour = 8'h21;
                    default: conv_hour = {2'b00, live[2][5:0] + 6'h12};
                endcase
            end
            else conv_hour = {2'b00, live[2][5:0]};
        end
    end

    integer i;
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            for (i = 0; i < 7; i = i + 1) begin
                live[i] <= ((i == 3) || (i == 4)) ? `RTCC_RST_ONE : 8'h00;
                shadow[i] <= 8'h00;
            end
            for (i = 0; i < 6; i = i + 1) begin
                alarm[i] <= ((i == 3) || (i == 4)) ? `RTCC_RST_ONE : 8'h00;
            end
            ctrl <= 8'h00;
            intr <= 8'h00;
            comp <= 16'h0000;
            sub <= 15'h0000;
            hour_secs <= 12'h000;
            alarm_flag <= 1'b0;
            pwr_flag <= 1'b1;
            run_state <= 1'b0;
            snap_armed <= 1'b1;
            sec_done <= 1'b0;
        end else begin
            // Run state changes only on a 32 kHz edge, so status lags control
            if (tick) begin
                run_state <= ctrl[`RTCC_C_RUN];
            end
            if (tick && run_live) begin
                sub <= sub + 15'h0001;
                if (comp_now) begin
                    sub <= comp[14:0];
                end
            end
            sec_done <= sec_update;
            // A round-up steps the same chain, so minute 59 still carries
            if (sec_update || round_up) begin
                // Only real seconds count toward the hourly compensation
                if (sec_update) begin
                    hour_secs <= (hour_secs == `RTCC_HOUR_SECS) ? 12'h000 :
                        hour_secs + 12'h001;
                end
                live[0] <= n_sec;
                if (w_sec || round_up) begin
                    live[1] <= n_min;
                    if (w_min) begin
                        live[2] <= {pm ^ pm_flip, 1'b0, n_hour[5:0]};
                        if (day_carry) begin
                            live[6] <= (live[6] == `RTCC_WEEK_LAST) ? 8'h00 :
                                live[6] + 8'h01;
                            live[3] <= n_day;
                            if (w_day) begin
                                live[4] <= n_mon;
                                if (w_mon) begin
                                    live[5] <= n_year;
                                end
                            end
                        end
                    end
                end
            end

            // Match once all fields hold their new value; set wins over host clear
            if (sec_done && intr[`RTCC_I_ALARM] && (&field_eq)) begin
                alarm_flag <= 1'b1;
            end else if (wr_i && (addr_i == `RTCC_A_STAT) && wdata_i[`RTCC_S_ALARM]) begin
                alarm_flag <= 1'b0;
            end
            if (wr_i && (addr_i == `RTCC_A_STAT) && wdata_i[`RTCC_S_PWR]) begin
                pwr_flag <= 1'b0;
            end

            // Rounding restarts the sub-second count so the new minute is whole
            if (round_go) begin
                live[0] <= 8'h00;
                sub <= 15'h0000;
                ctrl[`RTCC_C_ROUND] <= 1'b0;
            end
            if (wr_i && (addr_i <= `RTCC_A_WEEK)) begin
                live[addr_i[2:0]] <= wdata_i & tmask(addr_i[2:0]) &
                    ((addr_i == `RTCC_A_HOUR) && !h12 ? 8'h7f : 8'hff);
            end
            if (wr_i && (addr_i >= `RTCC_A_ASEC) && (addr_i <= `RTCC_A_AYEAR)) begin
                alarm[addr_i[2:0]] <= wdata_i & tmask(addr_i[2:0]) &
                    ((addr_i == `RTCC_A_AHOUR) && !h12 ? 8'h7f : 8'hff);
            end
            if (wr_i && (addr_i == `RTCC_A_INTR)) begin
                intr <= wdata_i & `RTCC_MASK_INTR;
            end
            if (wr_i && (addr_i == `RTCC_A_CMPL)) begin
                comp[7:0] <= wdata_i;
            end
            if (wr_i && (addr_i == `RTCC_A_CMPM)) begin
                comp[15:8] <= wdata_i;
            end
            if (wr_ctrl) begin
                ctrl <= {wdata_i[7:2], wdata_i[`RTCC_C_ROUND] | ctrl[`RTCC_C_ROUND],
                    wdata_i[0]};
                if (wdata_i[`RTCC_C_H12] != h12) begin
                    live[2] <= conv_hour;
                end
                snap_armed <= ~wdata_i[`RTCC_C_SNAP];
                if (wdata_i[`RTCC_C_SNAP] && snap_armed) begin
                    for (i = 0; i < 7; i = i + 1) begin
                        shadow[i] <= live[i];
                    end
                end
                if (wdata_i[`RTCC_C_LOAD]) begin
                    sub <= comp[14:0];
                end
            end
        end
    end

    assign stat = {pwr_flag, alarm_flag, 4'h0, run_state, 1'b0};
    assign alarm_irq_n_o = ~alarm_flag;

    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (addr_i <= `RTCC_A_WEEK) begin
                rdata_o <= ctrl[`RTCC_C_RSEL] ? shadow[addr_i[2:0]] :
                    live[addr_i[2:0]];
            end else if ((addr_i >= `RTCC_A_ASEC) && (addr_i <= `RTCC_A_AYEAR)) begin
                rdata_o <= alarm[addr_i[2:0]];
            end else begin
                case (addr_i)
                    `RTCC_A_CTRL: rdata_o <= ctrl;
                    `RTCC_A_STAT: rdata_o <= stat;
                    `RTCC_A_INTR: rdata_o <= intr;
                    `RTCC_A_CMPL: rdata_o <= comp[7:0];
                    `RTCC_A_CMPM: rdata_o <= comp[15:8];
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule // rtcc_core

// [rtcc_core_props.sv]
// Assertion checker for the calendar/alarm register block
`timescale 1ns/100ps
module rtcc_core_chk (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire clk32k_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire [7:0] rdata_o,
    input wire alarm_irq_n_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_rdata_reset_zero: assert property (disable iff (1'b0)
        !rstn_i |=> rdata_o == 8'h00) else $error("read data not cleared by reset");
    a_irq_reset_high: assert property (disable iff (1'b0)
        !rstn_i |=> alarm_irq_n_o) else $error("alarm line low after reset");
    a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (rd_i && (addr_i == 8'h07 || addr_i > 8'h14)
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    a_week_upper_zero: assert property (rd_i && addr_i == 8'h06
        |=> rdata_o[7:3] == 5'h00) else $error("weekday reserved bits set");
    a_alarm_top_zero: assert property (rd_i && (addr_i == 8'h08 || addr_i == 8'h09)
        |=> !rdata_o[7]) else $error("alarm sec/min bit 7 set");
    a_aday_upper_zero: assert property (rd_i && addr_i == 8'h0b
        |=> rdata_o[7:6] == 2'h0) else $error("alarm day reserved bits set");
    a_amon_upper_zero: assert property (rd_i && addr_i == 8'h0c
        |=> rdata_o[7:5] == 3'h0) else $error("alarm month reserved bits set");
    a_irq_stays_low: assert property (!alarm_irq_n_o
        && !(wr_i && addr_i == 8'h11 && wdata_i[6]) |-> ##1 !alarm_irq_n_o)
        else $error("alarm line released without clear");
endmodule // rtcc_core_chk

bind rtcc_core rtcc_core_chk u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .clk32k_i(clk32k_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .alarm_irq_n_o(alarm_irq_n_o));

// [rtcc_host_osc.sv]
// Free-running 12.5 MHz stand-in for the 32 kHz time base seen by the block
`timescale 1ns/100ps
module rtcc_host_osc (
    output logic clk32k_o
);
    // Odd start offset keeps its edges clear of the system clock edges
    initial begin
        clk32k_o = 1'b0;
        #13;
        forever #40 clk32k_o = ~clk32k_o;
    end
endmodule // rtcc_host_osc

// [rtcc_tb.sv]
// Directed register-level bench for the calendar/alarm block
`timescale 1ns/100ps
module tb;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    wire clk32k_i;
    wire [7:0] rdata_o;
    wire alarm_irq_n_o;
    int fails = 0;
    int total_checks = 0;
    int n;
    logic [7:0] v;
    logic [15:0] rst_tab [15] = '{16'h0000, 16'h0100, 16'h0200, 16'h0301, 16'h0401,
        16'h0500, 16'h0600, 16'h0800, 16'h0900, 16'h0a00, 16'h0b01, 16'h0c01, 16'h0d00,
        16'h1000, 16'h0700};
    // Address, written value, expected readback
    logic [23:0] wr_tab [10] = '{24'h059999, 24'h06f606, 24'h08d959, 24'h09d959,
        24'h0aa323, 24'h0bf131, 24'h0cf212, 24'h0d9999, 24'h00d959, 24'h075500};
    logic [15:0] ro_tab [16] = '{16'h0059, 16'h0159, 16'h0223, 16'h0331, 16'h0412,
        16'h0599, 16'h0606, 16'h0800, 16'h0900, 16'h0a00, 16'h0b01, 16'h0c01, 16'h0d00,
        16'h13fc, 16'h147f, 16'h1208};
    logic [15:0] new_tab [6] = '{16'h0100, 16'h0200, 16'h0301, 16'h0401, 16'h0500,
        16'h0600};

    always #2 ref_clk_i = ~ref_clk_i;

    rtcc_host_osc u_osc (.clk32k_o(clk32k_i));
    rtcc_core DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk32k_i(clk32k_i),
        .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .alarm_irq_n_o(alarm_irq_n_o));

    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task check(input [7:0] g, input [7:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        @(negedge ref_clk_i);
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(negedge ref_clk_i);
        wr_i = 1'b0;
    endtask

    task get(input [7:0] a, output [7:0] d);
        @(negedge ref_clk_i);
        rd_i = 1'b1;
        addr_i = a;
        @(negedge ref_clk_i);
        rd_i = 1'b0;
        @(negedge ref_clk_i);
        d = rdata_o;
    endtask

    task rchk(input [7:0] a, input [7:0] e);
        get(a, v);
        check(v, e);
    endtask

    // Status reads are preceded by a throwaway read so the value is fresh
    task poll(input [7:0] a, input [7:0] m, input [7:0] e);
        for (n = 0; n < 400; n++) begin
            if (a == 8'h11) get(a, v);
            get(a, v);
            if ((v & m) === e) break;
        end
        if (n == 400) begin
            fails++;
            $display("CHECK FAILED at %0t: wait on %h timed out", $time, a);
            end_of_test;
        end
    endtask

    initial begin
        repeat (16) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        foreach (rst_tab[i]) rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
        poll(8'h11, 8'hff, 8'h80);
        $display("test reset values done");
        foreach (wr_tab[i]) wr(wr_tab[i][23:16], wr_tab[i][15:8]);
        foreach (wr_tab[i]) rchk(wr_tab[i][23:16], wr_tab[i][7:0]);
        $display("test field layout done");
        wr(8'h00, 8'h12);
        wr(8'h10, 8'h40);
        wr(8'h00, 8'h34);
        wr(8'h10, 8'h80);
        rchk(8'h00, 8'h12);
        wr(8'h10, 8'h00);
        rchk(8'h00, 8'h34);
        wr(8'h10, 8'hc0);
        wr(8'h00, 8'h45);
        wr(8'h10, 8'hc0);
        wr(8'h10, 8'h80);
        rchk(8'h00, 8'h34);
        wr(8'h10, 8'h00);
        $display("test snapshot done");
        // Counter is loaded near its end so the first second comes quickly
        foreach (ro_tab[i]) wr(ro_tab[i][15:8], ro_tab[i][7:0]);
        wr(8'h10, 8'h20);
        check({7'h00, alarm_irq_n_o}, 8'h01);
        wr(8'h10, 8'h01);
        poll(8'h11, 8'h02, 8'h02);
        poll(8'h00, 8'hff, 8'h00);
        check({7'h00, alarm_irq_n_o}, 8'h00);
        wr(8'h10, 8'h00);
        foreach (new_tab[i]) rchk(new_tab[i][15:8], new_tab[i][7:0]);
        poll(8'h11, 8'h40, 8'h40);
        wr(8'h11, 8'h40);
        check({7'h00, alarm_irq_n_o}, 8'h01);
        $display("test rollover and alarm done");
        wr(8'h00, 8'h45);
        wr(8'h01, 8'h10);
        wr(8'h10, 8'h02);
        rchk(8'h10, 8'h00);
        rchk(8'h01, 8'h11);
        rchk(8'h00, 8'h00);
        wr(8'h02, 8'h23);
        wr(8'h10, 8'h1c);
        rchk(8'h10, 8'h1c);
        rchk(8'h02, 8'h91);
        wr(8'h10, 8'h3c);
        wr(8'h10, 8'h1d);
        poll(8'h00, 8'hff, 8'h02);
        wr(8'h10, 8'h1c);
        wr(8'h02, 8'h88);
        wr(8'h10, 8'h00);
        rchk(8'h02, 8'h20);
        wr(8'h01, 8'h59);
        wr(8'h00, 8'h31);
        wr(8'h10, 8'h02);
        rchk(8'h02, 8'h21);
        rchk(8'h01, 8'h00);
        $display("test round and modes done");
        end_of_test;
    end
endmodule // tb
